// ### rtl/bspwm_defs.svh
// Constants for the brake sequencer and its PWM generator
`ifndef BSPWM_DEFS_SVH
`define BSPWM_DEFS_SVH
`define BSPWM_CLK_HZ          32'd10000000
`define BSPWM_FREQ_MAX        16'd20000
`define BSPWM_DUTY_MIN        7'd2
`define BSPWM_DUTY_FULL       7'd100
`define BSPWM_FREQ_RST        16'd1000
`define BSPWM_DUTY_RST        7'd100
`define BSPWM_MS_CYCLES       14'd10000
`define BSPWM_ADR_CTRL        4'h0
`define BSPWM_ADR_DOUT        4'h1
`define BSPWM_ADR_PREENG      4'h2
`define BSPWM_ADR_POSTENG     4'h3
`define BSPWM_ADR_PREREL      4'h4
`define BSPWM_ADR_POSTREL     4'h5
`define BSPWM_ADR_FREQ        4'h6
`define BSPWM_ADR_DUTY        4'h7
`define BSPWM_ADR_STAT        4'h8
`define BSPWM_BIT_AUTO        2
`define BSPWM_BIT_OPREQ       0
`define BSPWM_BIT_BRAKE       0
`endif

// ### rtl/bspwm_pkg.sv
// Types for the brake sequencer
package bspwm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE_REL, ST_POST_REL, ST_OPEN, ST_STOPPING, ST_PRE_ENG, ST_POST_ENG
  } bspwm_state_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [6:0]  duty;
  } bspwm_cfg_t;
endpackage : bspwm_pkg

// ### rtl/bspwm_gen.sv
// Brake PWM waveform generator
`timescale 1ns/100ps
`include "bspwm_defs.svh"
module bspwm_gen (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Control
  input  wire logic               enable,
  input  wire bspwm_pkg::bspwm_cfg_t cfg,
  // Waveform
  output logic                    pwmOut
);
  logic [23:0] period_q;
  logic [23:0] high_q;
  logic [23:0] count_q;
  logic        pwm_q;
  logic [23:0] periodNew;
  logic [30:0] highProd;

  assign periodNew = (cfg.freq == 16'h0000) ? 24'hFFFFFF :
                     24'(`BSPWM_CLK_HZ / {16'h0000, cfg.freq});
  assign highProd  = 31'(periodNew) * 31'(cfg.duty);

  always_ff @(posedge core_clk) begin
    if (rst || !enable) begin
      count_q  <= 24'h000000;
      period_q <= periodNew;
      high_q   <= 24'(highProd / 31'd100);
    end else if (count_q >= period_q - 24'h000001) begin
      count_q  <= 24'h000000;
      period_q <= periodNew;
      high_q   <= 24'(highProd / 31'd100);
    end else begin
      count_q <= count_q + 24'h000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= enable && (count_q < high_q);
    end
  end
  assign pwmOut = pwm_q;

  a_full_duty: assert property (@(posedge core_clk) disable iff (rst)
    (!$past(rst) && $past(enable) && $past(high_q >= period_q)) |-> pwmOut)
    else $error("full duty output not steady");
  // settings change only on a wrap
  a_reload_boundary: assert property (@(posedge core_clk) disable iff (rst)
    (!$past(rst) && $past(enable) && ($changed(period_q) || $changed(high_q)))
    |-> count_q == 24'h000000)
    else $error("waveform settings changed inside a period");
endmodule : bspwm_gen

// ### rtl/brake_sequencer_pwm.sv
// Brake sequencer with Wishbone registers and PWM output
`timescale 1ns/100ps
`include "bspwm_defs.svh"
// Functional notes
// - Auto mode: brake closed in idle, pre-release and post-engage
// - Auto bit set: sequence brake from state
// - Auto bit clear: brake follows manual bit
// - Current on, pre-release delay, then release
// - Post-release delay before operation enabled
// - Standstill, pre-engage delay, then engage
// - Post-engage delay, then current off
// - Released brake output is PWM waveform
// - Frequency in hertz, above 20000 refused
// - Duty whole percent from 2 to 100
// - Duty 100 holds output steadily on
// - Digital output bit zero is brake
module brake_sequencer_pwm (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Drive interface
  input  wire logic        motorStandstill,
  output logic             motorCurrentOn,
  output logic             haltRequest,
  output logic             operationEnabled,
  // Open-drain brake pin
  input  wire logic        brakePin_i,
  output logic             brakePin_o,
  output logic             brakePin_oe
);
  logic [31:0]               ctrl_q;
  logic [31:0]               dout_q;
  logic [15:0]               preEng_q;
  logic [15:0]               postEng_q;
  logic [15:0]               preRel_q;
  logic [15:0]               postRel_q;
  bspwm_pkg::bspwm_cfg_t     cfg_q;
  logic                      ack_q;
  logic [31:0]               rdat_q;
  bspwm_pkg::bspwm_state_t   state_q;
  logic [15:0]               msCnt_q;
  logic [13:0]               tick_q;
  logic                      brakeOpen;
  logic                      pwmOut;
  logic                      pinSync1_q;
  logic                      pinSync2_q;
  logic                      wbReq;
  logic                      wrStb;
  logic [3:0]                regIdx;
  logic                      autoMode;
  logic                      opReq;
  logic                      msTick;
  logic [15:0]               wrFreq;
  logic [6:0]                wrDuty;

  assign wbReq    = wb_cyc_i && wb_stb_i && !ack_q;
  // Writes land on the edge where the master samples ack high
  assign wrStb    = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign regIdx   = wb_adr_i[5:2];
  assign autoMode = ctrl_q[`BSPWM_BIT_AUTO];
  assign opReq    = ctrl_q[`BSPWM_BIT_OPREQ];
  assign wrFreq   = wb_dat_i[15:0];
  assign wrDuty   = wb_dat_i[6:0];

  // Single-cycle ack; drops on the next cycle even while strobe is held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wbReq;
    end
  end
  assign wb_ack_o = ack_q;

  // Byte-lane-masked writes for plain registers
  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : mergeSel

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q    <= 32'h00000000;
      dout_q    <= 32'h00000000;
      preEng_q  <= 16'h0000;
      postEng_q <= 16'h0000;
      preRel_q  <= 16'h0000;
      postRel_q <= 16'h0000;
    end else if (wrStb) begin
      unique case (regIdx)
        `BSPWM_ADR_CTRL:    ctrl_q    <= mergeSel(ctrl_q, wb_dat_i, wb_sel_i);
        `BSPWM_ADR_DOUT:    dout_q    <= mergeSel(dout_q, wb_dat_i, wb_sel_i);
        `BSPWM_ADR_PREENG:  preEng_q  <= 16'(mergeSel({16'h0000, preEng_q}, wb_dat_i, wb_sel_i));
        `BSPWM_ADR_POSTENG: postEng_q <= 16'(mergeSel({16'h0000, postEng_q}, wb_dat_i, wb_sel_i));
        `BSPWM_ADR_PREREL:  preRel_q  <= 16'(mergeSel({16'h0000, preRel_q}, wb_dat_i, wb_sel_i));
        `BSPWM_ADR_POSTREL: postRel_q <= 16'(mergeSel({16'h0000, postRel_q}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // refuse duty outside 2..100
  // Whole-value writes only; partial lanes would allow illegal halves
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q.freq <= `BSPWM_FREQ_RST;
      cfg_q.duty <= `BSPWM_DUTY_RST;
    end else if (wrStb) begin
      if (regIdx == `BSPWM_ADR_FREQ && wb_sel_i[1:0] == 2'h3 && wb_dat_i[31:16] == 16'h0000
          && wrFreq <= `BSPWM_FREQ_MAX) begin
        cfg_q.freq <= wrFreq;
      end
      if (regIdx == `BSPWM_ADR_DUTY && wb_sel_i[0] && wb_dat_i[31:7] == 25'h0000000
          && wrDuty >= `BSPWM_DUTY_MIN && wrDuty <= `BSPWM_DUTY_FULL) begin
        cfg_q.duty <= wrDuty;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdat_q <= 32'h00000000;
    end else if (wbReq && !wb_we_i) begin
      unique case (regIdx)
        `BSPWM_ADR_CTRL:    rdat_q <= ctrl_q;
        `BSPWM_ADR_DOUT:    rdat_q <= dout_q;
        `BSPWM_ADR_PREENG:  rdat_q <= {16'h0000, preEng_q};
        `BSPWM_ADR_POSTENG: rdat_q <= {16'h0000, postEng_q};
        `BSPWM_ADR_PREREL:  rdat_q <= {16'h0000, preRel_q};
        `BSPWM_ADR_POSTREL: rdat_q <= {16'h0000, postRel_q};
        `BSPWM_ADR_FREQ:    rdat_q <= {16'h0000, cfg_q.freq};
        `BSPWM_ADR_DUTY:    rdat_q <= {25'h0000000, cfg_q.duty};
        `BSPWM_ADR_STAT:    rdat_q <= {24'h000000, pinSync2_q, 1'b0, state_q, brakeOpen,
                                       motorCurrentOn, operationEnabled};
        default:            rdat_q <= 32'h00000000;
      endcase
    end
  end
  assign wb_dat_o = rdat_q;

  // Millisecond tick for the delay timers
  always_ff @(posedge core_clk) begin
    if (rst || tick_q == `BSPWM_MS_CYCLES - 14'h0001) begin
      tick_q <= 14'h0000;
    end else begin
      tick_q <= tick_q + 14'h0001;
    end
  end
  assign msTick = (tick_q == `BSPWM_MS_CYCLES - 14'h0001);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= bspwm_pkg::ST_IDLE;
      msCnt_q <= 16'h0000;
    end else begin
      if (msTick) begin
        msCnt_q <= msCnt_q + 16'h0001;
      end
      unique case (state_q)
        bspwm_pkg::ST_IDLE: begin
          msCnt_q <= 16'h0000;
          if (autoMode && opReq) begin
            state_q <= bspwm_pkg::ST_PRE_REL;
          end
        end
        bspwm_pkg::ST_PRE_REL: begin
          if (!(autoMode && opReq)) begin
            state_q <= bspwm_pkg::ST_POST_ENG;
            msCnt_q <= 16'h0000;
          end else if (msCnt_q >= preRel_q) begin
            state_q <= bspwm_pkg::ST_POST_REL;
            msCnt_q <= 16'h0000;
          end
        end
        bspwm_pkg::ST_POST_REL: begin
          if (!(autoMode && opReq)) begin
            state_q <= bspwm_pkg::ST_STOPPING;
          end else if (msCnt_q >= postRel_q) begin
            state_q <= bspwm_pkg::ST_OPEN;
          end
        end
        bspwm_pkg::ST_OPEN: begin
          if (!(autoMode && opReq)) begin
            state_q <= bspwm_pkg::ST_STOPPING;
          end
        end
        bspwm_pkg::ST_STOPPING: begin
          msCnt_q <= 16'h0000;
          if (motorStandstill) begin
            state_q <= bspwm_pkg::ST_PRE_ENG;
          end
        end
        bspwm_pkg::ST_PRE_ENG: begin
          if (msCnt_q >= preEng_q) begin
            state_q <= bspwm_pkg::ST_POST_ENG;
            msCnt_q <= 16'h0000;
          end
        end
        bspwm_pkg::ST_POST_ENG: begin
          if (msCnt_q >= postEng_q) begin
            state_q <= bspwm_pkg::ST_IDLE;
          end
        end
        default: state_q <= bspwm_pkg::ST_IDLE;
      endcase
    end
  end

  assign motorCurrentOn   = autoMode && (state_q != bspwm_pkg::ST_IDLE);
  assign haltRequest      = state_q == bspwm_pkg::ST_STOPPING;
  assign operationEnabled = state_q == bspwm_pkg::ST_OPEN;

  always_comb begin
    if (autoMode) begin
      brakeOpen = (state_q == bspwm_pkg::ST_POST_REL) || (state_q == bspwm_pkg::ST_OPEN)
                  || (state_q == bspwm_pkg::ST_STOPPING) || (state_q == bspwm_pkg::ST_PRE_ENG);
    end else begin
      brakeOpen = dout_q[`BSPWM_BIT_BRAKE];
    end
  end

  bspwm_gen uGen (
    .core_clk (core_clk),
    .rst      (rst),
    .enable   (brakeOpen),
    .cfg      (cfg_q),
    .pwmOut   (pwmOut)
  );

  // Pin readback, only for status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
    end else begin
      pinSync1_q <= brakePin_i;
      pinSync2_q <= pinSync1_q;
    end
  end

  // Open drain: pull low when the coil is energised
  assign brakePin_o  = 1'b0;
  assign brakePin_oe = pwmOut;

  // Delay phases that must not have ended yet
  sequence s_rel_wait;
    state_q == bspwm_pkg::ST_PRE_REL && autoMode && opReq && msCnt_q < preRel_q;
  endsequence
  sequence s_open_wait;
    state_q == bspwm_pkg::ST_POST_REL && autoMode && opReq && msCnt_q < postRel_q;
  endsequence
  sequence s_eng_wait;
    state_q == bspwm_pkg::ST_PRE_ENG && msCnt_q < preEng_q;
  endsequence
  sequence s_off_wait;
    state_q == bspwm_pkg::ST_POST_ENG && msCnt_q < postEng_q;
  endsequence

  // brake closed in idle auto mode
  a_idle_closed: assert property (@(posedge core_clk) disable iff (rst)
    (autoMode && state_q == bspwm_pkg::ST_IDLE) |-> !brakeOpen)
    else $error("brake open while idle in auto mode");
  // closed brake stops the pin drive
  a_brake_drop: assert property (@(posedge core_clk) disable iff (rst)
    !brakeOpen |=> !brakePin_oe)
    else $error("brake pin driven while brake closed");
  a_auto_start: assert property (@(posedge core_clk) disable iff (rst)
    (autoMode && opReq && state_q == bspwm_pkg::ST_IDLE) |=> state_q == bspwm_pkg::ST_PRE_REL)
    else $error("auto request did not start the sequence");
  a_manual_follow: assert property (@(posedge core_clk) disable iff (rst)
    !autoMode |-> brakeOpen == dout_q[`BSPWM_BIT_BRAKE])
    else $error("manual brake does not follow bit");
  a_current_first: assert property (@(posedge core_clk) disable iff (rst)
    (autoMode && $past(autoMode) && $rose(brakeOpen)) |-> $past(motorCurrentOn))
    else $error("brake released without motor current");
  a_release_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_rel_wait |=> state_q == bspwm_pkg::ST_PRE_REL)
    else $error("brake released before pre-release delay");
  a_open_entry: assert property (@(posedge core_clk) disable iff (rst)
    $rose(operationEnabled) |-> $past(state_q) == bspwm_pkg::ST_POST_REL && brakeOpen)
    else $error("operation enabled without released brake");
  a_enable_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_open_wait |=> !operationEnabled)
    else $error("operation enabled before post-release delay");
  a_engage_still: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == bspwm_pkg::ST_STOPPING && !motorStandstill) |=> state_q != bspwm_pkg::ST_PRE_ENG)
    else $error("engage sequence without standstill");
  a_engage_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_eng_wait |=> state_q == bspwm_pkg::ST_PRE_ENG)
    else $error("brake engaged before pre-engage delay");
  a_current_off: assert property (@(posedge core_clk) disable iff (rst)
    (autoMode && $fell(motorCurrentOn)) |-> $past(state_q) == bspwm_pkg::ST_POST_ENG)
    else $error("current off outside post-engage");
  a_off_delay: assert property (@(posedge core_clk) disable iff (rst)
    s_off_wait |=> state_q == bspwm_pkg::ST_POST_ENG)
    else $error("current off before post-engage delay");
  a_freq_limit: assert property (@(posedge core_clk) disable iff (rst)
    cfg_q.freq <= `BSPWM_FREQ_MAX)
    else $error("frequency above limit");
  a_duty_range: assert property (@(posedge core_clk) disable iff (rst)
    cfg_q.duty >= `BSPWM_DUTY_MIN && cfg_q.duty <= `BSPWM_DUTY_FULL)
    else $error("duty out of range");
  // Bus ack is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule : brake_sequencer_pwm

// ### testbench/bspwm_partner.sv
// Far-side model: brake coil on the open-drain pin and the motor drive
`timescale 1ns/100ps
module bspwm_partner (
  // Clock
  input  wire logic core_clk,
  // Drive side
  input  wire logic haltRequest,
  output logic      motorStandstill,
  // Brake pin
  input  wire logic brakePin_o,
  input  wire logic brakePin_oe,
  output logic      brakePin_i
);
  int stopCnt = 0;
  // Coil supply pulls the pin high once it is released
  assign brakePin_i = brakePin_oe ? brakePin_o : 1'b1;
  // Motor coasts a while before it reports rest
  always @(posedge core_clk) stopCnt <= haltRequest ? stopCnt + 1 : 0;
  assign motorStandstill = haltRequest && stopCnt >= 20;
endmodule : bspwm_partner

// ### testbench/tb_top.sv
// Self-checking bench for the brake sequencer
`timescale 1ns/100ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdOut, q;
  logic        ack, still, curOn, halt, opEn, pinIn, pinOut, pinOe;
  int          err_count = 0, compares = 0, cycN = 0, n, h;
  logic [3:0]  rI [11] = '{4'h6, 4'h6, 4'h7, 4'h7, 4'h7, 4'h7, 4'h9, 4'h2, 4'h3, 4'h4, 4'h5};
  logic [31:0] rW [11] = '{32'h4E20, 32'h4E21, 32'h2, 32'h1, 32'h65, 32'h64, 32'h5,
                           32'h1, 32'h2, 32'h2, 32'h2};
  logic [31:0] rE [11] = '{32'h4E20, 32'h4E20, 32'h2, 32'h2, 32'h2, 32'h64, 32'h0,
                           32'h1, 32'h2, 32'h2, 32'h2};

  always #50 core_clk = ~core_clk;

  brake_sequencer_pwm dut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdOut), .wb_ack_o(ack),
    .motorStandstill(still), .motorCurrentOn(curOn), .haltRequest(halt),
    .operationEnabled(opEn), .brakePin_i(pinIn), .brakePin_o(pinOut), .brakePin_oe(pinOe));

  bspwm_partner partner (
    .core_clk(core_clk), .haltRequest(halt), .motorStandstill(still),
    .brakePin_o(pinOut), .brakePin_oe(pinOe), .brakePin_i(pinIn));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic single cycle; held until ack is seen, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    sel <= 4'hF;
    dat <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) err_count++;
    q = rdOut;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  // Cycles until pin on, enabled, pin off, current off
  task automatic wt(input int c);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!((c == 0 && pinOe === 1'b1) || (c == 1 && opEn === 1'b1) ||
                 (c == 2 && pinOe === 1'b0) || (c == 3 && curOn === 1'b0)) && n < 40000);
    if (n >= 40000) err_count++;
  endtask : wt

  task automatic hi(input int m);
    h = 0;
    repeat (m) begin
      @(posedge core_clk);
      h += (pinOe === 1'b1);
    end
  endtask : hi

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  always @(posedge core_clk) begin
    cycN++;
    if (cycN == 100000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("oe reset", 32'h0, pinOe);
    chk("pin level", 32'h0, pinOut);
    wb(0, 4'h6, 0);
    chk("freq reset", 32'h3E8, q);
    wb(0, 4'h7, 0);
    chk("duty reset", 32'h64, q);
    wb(0, 4'h8, 0);
    chk("stat reset", 32'h80, q & 32'hFF);
    for (int i = 0; i < 11; i++) begin
      wb(1, rI[i], rW[i]);
      wb(0, rI[i], 0);
      chk("register", rE[i], q);
    end
    // Manual mode at full duty
    wb(1, 4'h0, 0);
    wb(1, 4'h1, 1);
    hi(600);
    hi(1000);
    chk("manual on", 32'd1000, h);
    wb(0, 4'h8, 0);
    chk("stat manual", 32'h04, q & 32'hFF);
    wb(1, 4'h1, 0);
    hi(10);
    hi(100);
    chk("manual off", 32'h0, h);
    // Automatic mode, manual bit left set
    wb(1, 4'h1, 1);
    wb(1, 4'h0, 4);
    hi(10);
    hi(100);
    chk("auto closed", 32'h0, h);
    wb(1, 4'h7, 50);
    wb(1, 4'h0, 5);
    hi(100);
    chk("pre release", 32'h0, h);
    chk("current on", 32'h1, curOn);
    wt(0);
    chk("release wait", 32'h1, n >= 9900);
    chk("not yet on", 32'h0, opEn);
    wt(1);
    chk("enable wait", 32'h1, n >= 9900);
    wb(0, 4'h8, 0);
    chk("stat open", 32'h1F, q & 32'h3F);
    hi(5000);
    chk("pwm high", 32'd2500, h);
    // Full duty again so a high pin means engaged
    wb(1, 4'h7, 100);
    hi(600);
    wb(1, 4'h0, 4);
    hi(2);
    chk("halt", 32'h1, halt);
    wt(2);
    chk("engage wait", 32'h1, n >= 18);
    chk("current held", 32'h1, curOn);
    wt(3);
    chk("off wait", 32'h1, n >= 9900);
    chk("disabled", 32'h0, opEn);
    conclude();
  end
endmodule : tb_top
